// file: rtl/pcss_top.sv
// Peripheral clock source select: AHB-Lite registers and sampled clock routing
// Notes on behaviour
// RULE_01: Bits 27-26 pick the serial port clock: off, loop clock, oscillator reference, internal reference.
// RULE_02: Bits 25-24 pick the timer counter clock with the same four-way encoding.
// RULE_03: Bit 18 picks the USB clock from the bypass pin or the loop clock.
// RULE_04: Bit 16 picks the loop clock: 0 the FLL output, 1 the PLL output divided by two.
// RULE_05: Bits 7-5 route bus, low-power, internal or oscillator clock to the output pin, other codes reserved.
// RULE_06: Bit 4 drives the RTC output pin from the 1 Hz tick when 0 and the oscillator reference when 1.
// RULE_07: Second register bit 26 picks external pin 0 or 1 for timer 2.
// RULE_08: Second register bit 25 is the external pin select for timer 1.
// RULE_09: Reserved bits of both registers are read-only and read as zero.
// RULE_10: For timer 1 a cleared select routes external pin 0 and a set one pin 1.
// RULE_11: Any loop-clock choice takes whatever the shared FLL/PLL select gives.
// RULE_12: USB select 0 takes the bypass pin and 1 the loop clock.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pcss_top
   import pcss_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pcss_src_s src_in,
   output pcss_clk_s clk_out
);

   logic [31:0] opt_reg;
   logic [31:0] pin_reg;
   logic wr_opt_q;
   logic wr_pin_q;
   logic [PCSS_SRC_W-1:0] sync_q1;
   logic [PCSS_SRC_W-1:0] sync_q2;
   logic pll_d;
   logic pll_half;
   logic bus_div;
   pcss_src_s s;
   logic periph_src;
   logic addr_ok;
   logic take_wr;
   logic take_rd;
   logic [1:0] ser_sel;
   logic [1:0] tim_sel;
   logic usb_sel;
   logic loop_sel;
   logic [2:0] out_sel;
   logic rtc_sel;
   logic t2_sel;
   logic t1_sel;
   logic [31:0] opt_view;
   logic [31:0] pin_view;

   // Four-way source pick shared by serial and timer selects
   function automatic logic src_pick(input logic [1:0] code, input pcss_src_s v, input logic loop);
      logic r;
      r = 1'b0;
      case (code)
         PCSS_SRC_OFF: r = 1'b0;
         PCSS_SRC_LOOP: r = loop;
         PCSS_SRC_OSC: r = v.osc;
         PCSS_SRC_IRC: r = v.irc;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Clock pins are foreign to hclk, so every one passes two flops
   genvar gi;
   generate
      for (gi = 0; gi < PCSS_SRC_W; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync_q1[gi] <= 1'b0;
               sync_q2[gi] <= 1'b0;
            end else begin
               sync_q1[gi] <= src_in[gi];
               sync_q2[gi] <= sync_q1[gi];
            end
         end
      end
   endgenerate

   assign s = sync_q2;

   assign ser_sel = opt_reg[PCSS_SERIAL_LSB+:2];
   assign tim_sel = opt_reg[PCSS_TIMER_LSB+:2];
   assign usb_sel = opt_reg[PCSS_USB_BIT];
   assign loop_sel = opt_reg[PCSS_LOOP_BIT];
   assign out_sel = opt_reg[PCSS_CLOCK_OUTPUT_PIN_LSB+:3];
   assign rtc_sel = opt_reg[PCSS_RTCOUT_BIT];
   assign t2_sel = pin_reg[PCSS_T2_BIT];
   assign t1_sel = pin_reg[PCSS_T1_BIT];

   // AHB-Lite address phase decode
   assign addr_ok = hsel && htrans[1] && hready;
   assign take_wr = addr_ok && hwrite;
   assign take_rd = addr_ok && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_opt_q <= 1'b0;
         wr_pin_q <= 1'b0;
      end else begin
         wr_opt_q <= take_wr && (haddr[PCSS_ADDR_W-1:0] == PCSS_OPT_OFFSET);
         wr_pin_q <= take_wr && (haddr[PCSS_ADDR_W-1:0] == PCSS_PIN_OFFSET);
      end
   end

   // Data phase write; only select fields are storable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opt_reg <= PCSS_OPT_RESET;
      end else if (wr_opt_q) begin
         opt_reg <= hwdata & PCSS_OPT_WMASK; // [RULE_09]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_reg <= PCSS_PIN_RESET;
      end else if (wr_pin_q) begin
         pin_reg <= hwdata & PCSS_PIN_WMASK; // [RULE_09]
      end
   end

   // Forward a pending write so a back-to-back read sees the new value
   assign opt_view = wr_opt_q ? (hwdata & PCSS_OPT_WMASK) : opt_reg;
   assign pin_view = wr_pin_q ? (hwdata & PCSS_PIN_WMASK) : pin_reg;

   // Zero wait states; read data launched from the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (take_rd && (haddr[PCSS_ADDR_W-1:0] == PCSS_OPT_OFFSET)) begin
            hrdata <= opt_view;
         end else if (take_rd && (haddr[PCSS_ADDR_W-1:0] == PCSS_PIN_OFFSET)) begin
            hrdata <= pin_view;
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // Halved PLL toggles on each rising edge of the sampled PLL
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_d <= 1'b0;
         pll_half <= 1'b0;
      end else begin
         pll_d <= s.pll;
         if (s.pll && !pll_d) begin
            pll_half <= !pll_half; // [RULE_04]
         end
      end
   end

   // Bus clock stand-in at half hclk, since hclk itself cannot leave a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_div <= 1'b0;
      end else begin
         bus_div <= !bus_div;
      end
   end

   assign periph_src = loop_sel ? pll_half : s.fll; // [RULE_04] [RULE_11]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_out <= '0;
      end else begin
         clk_out.periph <= periph_src; // [RULE_04]
         clk_out.serial <= src_pick(ser_sel, s, periph_src); // [RULE_01] [RULE_11]
         clk_out.timer <= src_pick(tim_sel, s, periph_src); // [RULE_02] [RULE_11]
         clk_out.usb <= usb_sel ? periph_src : s.usb_in; // [RULE_03] [RULE_12]
         clk_out.rtcout <= rtc_sel ? s.osc : s.rtc_tick; // [RULE_06]
         clk_out.timer2 <= t2_sel ? s.tclk1 : s.tclk0; // [RULE_07]
         clk_out.timer1 <= t1_sel ? s.tclk1 : s.tclk0; // [RULE_08] [RULE_10]
         case (out_sel) // [RULE_05]
            PCSS_OUT_BUS: clk_out.clock_output_pin <= bus_div;
            PCSS_OUT_LPO: clk_out.clock_output_pin <= s.low_power_oscillator;
            PCSS_OUT_IRC: clk_out.clock_output_pin <= s.irc;
            PCSS_OUT_OSC: clk_out.clock_output_pin <= s.osc;
            default: clk_out.clock_output_pin <= 1'b0;
         endcase
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_serial_off;
      ser_sel == PCSS_SRC_OFF |=> !clk_out.serial;
   endproperty
   a_serial_off: assert property (p_serial_off) else $error("serial clock not gated"); // [RULE_01]

   property p_serial_osc;
      ser_sel == PCSS_SRC_OSC |=> clk_out.serial == $past(s.osc);
   endproperty
   a_serial_osc: assert property (p_serial_osc) else $error("serial clock not oscillator"); // [RULE_01]

   property p_timer_irc;
      tim_sel == PCSS_SRC_IRC |=> clk_out.timer == $past(s.irc);
   endproperty
   a_timer_irc: assert property (p_timer_irc) else $error("timer clock not internal ref"); // [RULE_02]

   property p_usb_pin;
      !usb_sel |=> clk_out.usb == $past(s.usb_in);
   endproperty
   a_usb_pin: assert property (p_usb_pin) else $error("usb clock not bypass pin"); // [RULE_12]

   property p_usb_loop;
      usb_sel && loop_sel == 1'b0 |=> clk_out.usb == $past(s.fll);
   endproperty
   a_usb_loop: assert property (p_usb_loop) else $error("usb clock not loop clock"); // [RULE_03]

   property p_half_step;
      s.pll && !pll_d |=> pll_half != $past(pll_half);
   endproperty
   a_half_step: assert property (p_half_step) else $error("pll half did not toggle"); // [RULE_04]

   property p_half_hold;
      !(s.pll && !pll_d) |=> $stable(pll_half);
   endproperty
   a_half_hold: assert property (p_half_hold) else $error("pll half moved without edge"); // [RULE_04]

   property p_serial_loop;
      ser_sel == PCSS_SRC_LOOP && loop_sel |=> clk_out.serial == $past(pll_half);
   endproperty
   a_serial_loop: assert property (p_serial_loop) else $error("serial loop pick wrong"); // [RULE_11]

   property p_clock_output_pin_rsv;
      out_sel inside {3'h0, 3'h1, 3'h5, 3'h7} |=> !clk_out.clock_output_pin;
   endproperty
   a_clock_output_pin_rsv: assert property (p_clock_output_pin_rsv) else $error("reserved clock_output_pin code drives pin"); // [RULE_05]

   property p_clock_output_pin_bus;
      out_sel == PCSS_OUT_BUS ##1 out_sel == PCSS_OUT_BUS |=> clk_out.clock_output_pin != $past(clk_out.clock_output_pin);
   endproperty
   a_clock_output_pin_bus: assert property (p_clock_output_pin_bus) else $error("bus clock not toggling on pin"); // [RULE_05]

   property p_rtc_pick;
      1'b1 |=> clk_out.rtcout == ($past(rtc_sel) ? $past(s.osc) : $past(s.rtc_tick));
   endproperty
   a_rtc_pick: assert property (p_rtc_pick) else $error("rtc output pin source wrong"); // [RULE_06]

   property p_t2_pin;
      t2_sel |=> clk_out.timer2 == $past(s.tclk1);
   endproperty
   a_t2_pin: assert property (p_t2_pin) else $error("timer2 pin select wrong"); // [RULE_07]

   property p_t1_pin;
      !t1_sel |=> clk_out.timer1 == $past(s.tclk0);
   endproperty
   a_t1_pin: assert property (p_t1_pin) else $error("timer1 pin select wrong"); // [RULE_10]

   property p_rsv_zero;
      ((hrdata & ~(PCSS_OPT_WMASK | PCSS_PIN_WMASK)) == 32'h0000_0000) &&
      ((opt_reg & ~PCSS_OPT_WMASK) == 32'h0000_0000) && ((pin_reg & ~PCSS_PIN_WMASK) == 32'h0000_0000);
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero"); // [RULE_09]

   property p_write_lands;
      take_wr && haddr[PCSS_ADDR_W-1:0] == PCSS_PIN_OFFSET ##1 1'b1 |=> pin_reg == ($past(hwdata) & PCSS_PIN_WMASK);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("pin register write lost"); // [RULE_08]

   c_serial_loop: cover property (ser_sel == PCSS_SRC_LOOP && loop_sel ##1 clk_out.serial);
   c_clock_output_pin_bus: cover property (out_sel == PCSS_OUT_BUS ##2 clk_out.clock_output_pin);
   c_usb_pin: cover property (!usb_sel && s.usb_in ##1 clk_out.usb);
   c_t2_pin1: cover property (t2_sel && s.tclk1 ##1 clk_out.timer2);

endmodule
`default_nettype wire

// file: rtl/pcss_pkg.sv
// Shared constants and carrier types for the peripheral clock source select block
package pcss_pkg;
   localparam int PCSS_ADDR_W = 13;
   localparam logic [12:0] PCSS_OPT_OFFSET = 13'h1004;
   localparam logic [12:0] PCSS_PIN_OFFSET = 13'h100C;
   localparam logic [31:0] PCSS_OPT_RESET = 32'h0000_0000;
   localparam logic [31:0] PCSS_PIN_RESET = 32'h0000_0000;
   localparam logic [31:0] PCSS_OPT_WMASK = 32'h0F05_00F0;
   localparam logic [31:0] PCSS_PIN_WMASK = 32'h0600_0000;
   localparam int PCSS_SERIAL_LSB = 26;
   localparam int PCSS_TIMER_LSB = 24;
   localparam int PCSS_USB_BIT = 18;
   localparam int PCSS_LOOP_BIT = 16;
   localparam int PCSS_CLOCK_OUTPUT_PIN_LSB = 5;
   localparam int PCSS_RTCOUT_BIT = 4;
   localparam int PCSS_T2_BIT = 26;
   localparam int PCSS_T1_BIT = 25;
   localparam logic [1:0] PCSS_SRC_OFF = 2'h0;
   localparam logic [1:0] PCSS_SRC_LOOP = 2'h1;
   localparam logic [1:0] PCSS_SRC_OSC = 2'h2;
   localparam logic [1:0] PCSS_SRC_IRC = 2'h3;
   localparam logic [2:0] PCSS_OUT_BUS = 3'h2;
   localparam logic [2:0] PCSS_OUT_LPO = 3'h3;
   localparam logic [2:0] PCSS_OUT_IRC = 3'h4;
   localparam logic [2:0] PCSS_OUT_OSC = 3'h6;
   localparam int PCSS_SRC_W = 9;

   typedef struct packed {
      logic fll;
      logic pll;
      logic osc;
      logic irc;
      logic usb_in;
      logic low_power_oscillator;
      logic rtc_tick;
      logic tclk0;
      logic tclk1;
   } pcss_src_s;

   typedef struct packed {
      logic serial;
      logic timer;
      logic usb;
      logic clock_output_pin;
      logic rtcout;
      logic timer2;
      logic timer1;
      logic periph;
   } pcss_clk_s;
endpackage

// file: verification/pcss_bench.sv
// Self-checking bench for the peripheral clock source select block
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_source_select_bench;
   import pcss_pkg::*;
   typedef struct packed {
      logic [31:0] opt;
      logic [31:0] pin;
      pcss_src_s src;
      logic [7:0] exp;
   } pcss_row_s;
   localparam logic [31:0] OPT_A = {19'h0, PCSS_OPT_OFFSET};
   localparam logic [31:0] PIN_A = {19'h0, PCSS_PIN_OFFSET};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_s;
   logic [31:0] haddr, hwdata, hrdata, hr_s, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready;
   pcss_src_s src_in;
   pcss_clk_s clk_out;
   int error_cnt = 0;
   int checks = 0;
   pcss_row_s rows [4];
   assign hready = hreadyout;
   pcss_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .src_in(src_in), .clk_out(clk_out));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Edge-sampled copies avoid racing the registered bus outputs
   always @(posedge hclk) begin
      rdy_s <= hreadyout;
      hr_s <= hrdata;
   end
   task automatic results();
      $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: register got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: clocks got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         settle(1);
         n++;
      end while (rdy_s !== 1'b1 && n < 20);
      if (rdy_s !== 1'b1) begin
         error_cnt++;
         results();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      hsize <= 3'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      d = hr_s;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, rd);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, rd);
      cmp32(rd, exp);
   endtask
   initial begin
      logic last;
      int cnt;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      src_in = '0;
      rows[0] = '{32'h0000_0000, 32'h0000_0000, 9'h116, 8'h2F};
      rows[1] = '{32'h0604_0070, 32'h0400_0000, 9'h109, 8'hB5};
      rows[2] = '{32'h0B01_0080, 32'h0200_0000, 9'h14D, 8'h8A};
      rows[3] = '{32'h0D00_00D0, 32'h0000_0000, 9'h071, 8'hB8};
      repeat (12) @(posedge hclk);
      cmp8(clk_out, 8'h00);
      hresetn <= 1'b1;
      settle(1);
      rdc(OPT_A, PCSS_OPT_RESET);
      rdc(PIN_A, PCSS_PIN_RESET);
      cmp32({31'h0, hresp}, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(OPT_A, rows[i].opt);
         wr(PIN_A, rows[i].pin);
         rdc(OPT_A, rows[i].opt);
         rdc(PIN_A, rows[i].pin);
         src_in <= rows[i].src;
         settle(5);
         cmp8(clk_out, rows[i].exp);
      end
      $display("test table done");
      wr(OPT_A, 32'hFFFF_FFFF);
      rdc(OPT_A, PCSS_OPT_WMASK);
      wr(PIN_A, 32'hFFFF_FFFF);
      rdc(PIN_A, PCSS_PIN_WMASK);
      wr(32'h0000_1008, 32'hFFFF_FFFF);
      rdc(32'h0000_1008, 32'h0);
      rdc(OPT_A, PCSS_OPT_WMASK);
      $display("test reserved done");
      src_in <= '1;
      foreach (rows[i]) begin
         // Reserved output codes 000, 001, 101, 111 must leave the pin low
         wr(OPT_A, {24'h0, i[1], i[1] & i[0], i[1] | i[0], 5'h0});
         settle(5);
         cmp8({7'h0, clk_out.clock_output_pin}, 8'h00);
      end
      wr(OPT_A, 32'h0000_0040);
      settle(4);
      last = clk_out.clock_output_pin;
      settle(1);
      cmp8({7'h0, clk_out.clock_output_pin}, {7'h0, ~last});
      $display("test output pin done");
      for (int m = 0; m < 2; m++) begin
         // Loop source has a 4-cycle period; halved PLL gives half the transitions
         // Serial and timer also take the loop clock so its routing is exercised
         wr(OPT_A, m[0] ? 32'h0501_0000 : 32'h0500_0000);
         cnt = 0;
         for (int k = 0; k < 48; k++) begin
            src_in.pll <= k[1];
            src_in.fll <= k[1];
            settle(1);
            if (k >= 16 && clk_out.periph !== last)
               cnt++;
            last = clk_out.periph;
         end
         cmp8(cnt[7:0], m[0] ? 8'h08 : 8'h10);
      end
      $display("test loop clock done");
      results();
   end
endmodule
`default_nettype wire
